// [include/sw_slave_pkg.sv]
// Constants for the single-wire slave: command codes, timing in ns and derived cycle counts.
// Assumes a 40 MHz system clock.
package sw_slave_pkg;
  localparam int unsigned CLK_NS = 25;
  // Command codes
  localparam logic [7:0] CMD_RESUME       = 8'hA5;
  localparam logic [7:0] CMD_OD_SKIP      = 8'h3C;
  localparam logic [7:0] CMD_OD_MATCH     = 8'h69;
  localparam logic [7:0] CMD_MATCH        = 8'h55;
  localparam logic [7:0] CMD_SKIP         = 8'hCC;
  localparam logic [7:0] CMD_SEARCH       = 8'hF0;
  localparam logic [7:0] CMD_COND_SEARCH  = 8'hEC;
  localparam logic [7:0] CMD_READ_ROM     = 8'h33;
  localparam int unsigned ROM_BITS = 64;
  // Times in ns (standard / overdrive)
  localparam int unsigned RESET_LONG_NS      = 480000;
  localparam int unsigned RESET_SHORT_NS     = 80000;
  localparam int unsigned RESET_DETECT_STD_NS = 480000;
  localparam int unsigned RESET_DETECT_OD_NS  = 48000;
  localparam int unsigned PRES_WAIT_STD_NS   = 30000;
  localparam int unsigned PRES_WAIT_OD_NS    = 3000;
  localparam int unsigned PRES_LOW_STD_NS    = 120000;
  localparam int unsigned PRES_LOW_OD_NS     = 12000;
  localparam int unsigned SAMPLE_STD_NS      = 30000;
  localparam int unsigned SAMPLE_OD_NS       = 3000;
  localparam int unsigned READ_HOLD_STD_NS   = 30000;
  localparam int unsigned READ_HOLD_OD_NS    = 3000;
  // Cycle counts: least times round up
  localparam int unsigned CYC_RESET_LONG  = (RESET_LONG_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_RESET_SHORT = (RESET_SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_RST_DET_STD = (RESET_DETECT_STD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_RST_DET_OD  = (RESET_DETECT_OD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_PW_STD      = (PRES_WAIT_STD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_PW_OD       = (PRES_WAIT_OD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_PL_STD      = (PRES_LOW_STD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_PL_OD       = (PRES_LOW_OD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_SMP_STD     = (SAMPLE_STD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_SMP_OD      = (SAMPLE_OD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_RH_STD      = (READ_HOLD_STD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_RH_OD       = (READ_HOLD_OD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TMR_W = 16;
  localparam int unsigned CMD_BITS = 8;
endpackage : sw_slave_pkg

// [design/sw_slave.sv]
// Slave end of a single-conductor open-drain bus: reset/presence, bit slots,
// resume, overdrive skip and overdrive match addressing, resume flag and speed bit.
// Assumes the line input is asynchronous and the pad resolves the open-drain wire.
// Behaviour
// - Resume enters function stage only if flagged
// - Flag set only by successful addressing
// - Flag cleared when another device addressed
// - Overdrive skip: function stage, speed to overdrive
// - Long reset returns to standard speed
// - Short reset keeps overdrive speed
// - Overdrive match: 64 bits, exact match required
// - Overdrive kept when another device matched
// - Standard after power-up; overdrive times everything
// - Wait presence delay, then hold presence low
// - Falling edge starts timer; sample in window
// - Ready for new slot after recovery
// - Read zero pulls low, timer releases; one idle
`timescale 1ns/10ps
`default_nettype none
module sw_slave #(
  parameter logic [63:0] ROM_ID = 64'h0123_4567_89AB_CDEF, // Arbitrary identity
  parameter int unsigned RESET_LONG_CYC  = sw_slave_pkg::CYC_RESET_LONG,
  parameter int unsigned RESET_DET_STD   = sw_slave_pkg::CYC_RST_DET_STD,
  parameter int unsigned PRES_LOW_STD    = sw_slave_pkg::CYC_PL_STD
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Bus line, open drain
  input  wire logic       line_in,
  output logic            line_out,
  output logic            line_oe,
  // Control function stage
  output logic            func_active,
  output logic            func_bit_valid,
  output logic            func_bit,
  input  wire logic       func_tx_bit,
  // Status
  output logic            speed_select_bit,
  output logic            resume_select_flag
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_RESET_LOW, ST_PRES_WAIT, ST_PRES_LOW, ST_SLOT, ST_SLOT_END
  } line_st_t;
  typedef enum logic [2:0] {
    PH_CMD, PH_MATCH, PH_FUNC, PH_SEARCH, PH_READROM, PH_WAIT
  } phase_t;
  typedef struct packed {
    logic [1:0]  sync;
    line_st_t    st;
    phase_t      ph;
    logic [15:0] tmr;
    logic [6:0]  bitcnt;
    logic [7:0]  cmd;
    logic        match_ok;
    logic        od_pending;
    logic [1:0]  srch_step;
    logic        drive;
    logic        tx_bit;
    logic        speed;
    logic        resume;
    logic        fvalid;
    logic        fbit;
    logic        func;
  } state_t;

  state_t q, d;
  logic   line_s;
  logic   is_od;
  logic   rx_bit;
  logic   slot_done;
  logic   rom_bit;
  logic   rx_sample_at;
  assign line_s = q.sync[1];
  // An overdrive match is received fast before the speed bit may change
  assign is_od  = q.speed | q.od_pending;
  assign rom_bit = ROM_ID[q.bitcnt[5:0]];

  function automatic logic [15:0] pick(input logic od, input int unsigned s, input int unsigned o);
    pick = od ? o[15:0] : s[15:0];
  endfunction

  always_comb begin
    d = q;
    d.sync   = {q.sync[0], line_in};
    d.fvalid = 1'b0;
    rx_bit   = 1'b0;
    slot_done = 1'b0;
    rx_sample_at = 1'b0;
    if (q.tmr != 16'hFFFF) begin
      d.tmr = q.tmr + 16'h0001;
    end
    case (q.st)
      ST_IDLE: begin
        if (!line_s) begin
          d.st  = ST_SLOT;
          d.tmr = 16'h0000;
          d.drive = 1'b0;
          if ((q.ph == PH_FUNC && q.tx_bit == 1'b0) || (q.ph == PH_SEARCH &&
              q.srch_step != 2'd2 && (q.srch_step == 2'd0 ? !rom_bit : rom_bit)) ||
              (q.ph == PH_READROM && !rom_bit)) begin
            d.drive = 1'b1;
          end
        end
      end
      ST_SLOT: begin
        rx_sample_at = q.tmr == pick(is_od, sw_slave_pkg::CYC_SMP_STD, sw_slave_pkg::CYC_SMP_OD);
        if (q.tmr == pick(is_od, sw_slave_pkg::CYC_RH_STD, sw_slave_pkg::CYC_RH_OD)) begin
          d.drive = 1'b0;
        end
        if (rx_sample_at) begin
          rx_bit = line_s;
          slot_done = 1'b1;
        end
        if (q.tmr >= pick(is_od, RESET_DET_STD, sw_slave_pkg::CYC_RST_DET_OD)) begin
          d.st = ST_RESET_LOW;
          d.drive = 1'b0;
        end else if (line_s && q.tmr > pick(is_od, sw_slave_pkg::CYC_SMP_STD,
                     sw_slave_pkg::CYC_SMP_OD) && !q.drive) begin
          d.st = ST_IDLE;
        end
      end
      ST_RESET_LOW: begin
        if (line_s) begin
          // A short reset in overdrive leaves the speed bit alone
          if (q.tmr >= RESET_LONG_CYC[15:0]) begin
            d.speed = 1'b0;
          end
          d.od_pending = 1'b0;
          d.st  = ST_PRES_WAIT;
          d.tmr = 16'h0000;
          d.ph  = PH_CMD;
          d.bitcnt = 7'd0;
          d.drive = 1'b0;
        end
      end
      ST_PRES_WAIT: begin
        if (q.tmr >= pick(q.speed, sw_slave_pkg::CYC_PW_STD, sw_slave_pkg::CYC_PW_OD)) begin
          d.st = ST_PRES_LOW;
          // Starting at one makes the pull last exactly the presence count
          d.tmr = 16'h0001;
          d.drive = 1'b1;
        end
      end
      ST_PRES_LOW: begin
        if (q.tmr >= pick(q.speed, PRES_LOW_STD, sw_slave_pkg::CYC_PL_OD)) begin
          d.drive = 1'b0;
          d.st = ST_SLOT_END;
        end
      end
      ST_SLOT_END: begin
        if (line_s) begin
          d.st = ST_IDLE;
        end
      end
      default: d.st = ST_IDLE;
    endcase

    if (slot_done) begin
      case (q.ph)
        PH_CMD: begin
          d.cmd = {rx_bit, q.cmd[7:1]};
          d.bitcnt = q.bitcnt + 7'd1;
          if (q.bitcnt == 7'd7) begin
            d.bitcnt = 7'd0;
            d.match_ok = 1'b1;
            d.srch_step = 2'd0;
            case ({rx_bit, q.cmd[7:1]})
              sw_slave_pkg::CMD_RESUME: d.ph = q.resume ? PH_FUNC : PH_WAIT;
              sw_slave_pkg::CMD_OD_SKIP: begin
                d.ph = PH_FUNC;
                d.speed = 1'b1;
              end
              sw_slave_pkg::CMD_OD_MATCH: begin
                d.ph = PH_MATCH;
                d.od_pending = 1'b1;
              end
              sw_slave_pkg::CMD_MATCH: begin
                d.ph = PH_MATCH;
                d.od_pending = 1'b0;
              end
              sw_slave_pkg::CMD_SEARCH, sw_slave_pkg::CMD_COND_SEARCH: d.ph = PH_SEARCH;
              sw_slave_pkg::CMD_SKIP: d.ph = PH_FUNC;
              sw_slave_pkg::CMD_READ_ROM: d.ph = PH_READROM;
              default: d.ph = PH_WAIT;
            endcase
          end
        end
        PH_MATCH: begin
          d.match_ok = q.match_ok & (rx_bit == rom_bit);
          d.bitcnt = q.bitcnt + 7'd1;
          if (q.bitcnt == 7'(sw_slave_pkg::ROM_BITS - 1)) begin
            if (q.match_ok && rx_bit == rom_bit) begin
              d.ph = PH_FUNC;
              d.resume = 1'b1;
              d.speed = q.speed | q.od_pending;
            end else begin
              d.ph = PH_WAIT;
              d.resume = 1'b0;
              // Speed bit untouched: already-overdrive slaves stay fast
              d.speed = q.speed;
            end
            d.od_pending = 1'b0;
          end
        end
        PH_SEARCH: begin
          if (q.srch_step == 2'd2) begin
            d.srch_step = 2'd0;
            d.bitcnt = q.bitcnt + 7'd1;
            if (rx_bit != rom_bit) begin
              d.ph = PH_WAIT;
              d.resume = 1'b0;
            end else if (q.bitcnt == 7'(sw_slave_pkg::ROM_BITS - 1)) begin
              d.ph = PH_FUNC;
              d.resume = 1'b1;
            end
          end else begin
            d.srch_step = q.srch_step + 2'd1;
          end
        end
        PH_READROM: begin
          d.bitcnt = q.bitcnt + 7'd1;
          if (q.bitcnt == 7'(sw_slave_pkg::ROM_BITS - 1)) begin
            d.ph = PH_FUNC;
          end
        end
        PH_FUNC: begin
          d.fvalid = 1'b1;
          d.fbit = rx_bit;
        end
        default: d.ph = q.ph;
      endcase
    end
    // Next transmit bit is captured between slots so the drive decision is stable
    if (q.st != ST_SLOT) begin
      d.tx_bit = func_tx_bit;
    end
    d.func = (d.ph == PH_FUNC);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '{sync: 2'b11, st: ST_IDLE, ph: PH_WAIT, tmr: 16'h0000, bitcnt: 7'd0,
             cmd: 8'h00, match_ok: 1'b0, od_pending: 1'b0, srch_step: 2'd0,
             drive: 1'b0, tx_bit: 1'b1, speed: 1'b0, resume: 1'b0, fvalid: 1'b0,
             fbit: 1'b0, func: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign line_out           = 1'b0;
  assign line_oe            = q.drive;
  assign func_active        = q.func;
  assign func_bit_valid     = q.fvalid;
  assign func_bit           = q.fbit;
  assign speed_select_bit   = q.speed;
  assign resume_select_flag = q.resume;
endmodule : sw_slave
`default_nettype wire

// [tb/sw_slave_chk.sv]
// Checker for the single-wire slave, bound to its ports.
// Assumes line_in is the resolved, pulled-up bus level.
`timescale 1ns/10ps
`default_nettype none
module sw_slave_chk #(
  parameter int unsigned RESET_LONG_CYC = sw_slave_pkg::CYC_RESET_LONG,
  parameter int unsigned RESET_DET_STD  = sw_slave_pkg::CYC_RST_DET_STD,
  parameter int unsigned PRES_LOW_STD   = sw_slave_pkg::CYC_PL_STD
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Line and outputs
  input wire logic line_in,
  input wire logic line_out,
  input wire logic line_oe,
  input wire logic func_active,
  input wire logic func_bit_valid,
  input wire logic speed_select_bit,
  input wire logic resume_select_flag
);
  localparam int unsigned OD_DET = sw_slave_pkg::CYC_RST_DET_OD;
  localparam int unsigned DET_MIN = (RESET_DET_STD < OD_DET) ? RESET_DET_STD : OD_DET;
  // Raw low-run lengths; the design sees the line two cycles late
  int unsigned low_q;
  int unsigned last_q;
  int unsigned oe_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      low_q <= 0;
      last_q <= 0;
      oe_q <= 0;
    end else begin
      low_q <= line_in ? 0 : low_q + 1;
      if (line_in && low_q != 0) last_q <= low_q;
      oe_q <= line_oe ? oe_q + 1 : 0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_data_low: assert property (line_out == 1'b0) else $error("line_out not low");
  chk_valid_in_func: assert property (func_bit_valid |-> func_active)
    else $error("bit outside function stage");
  chk_valid_pulse: assert property (func_bit_valid |=> !func_bit_valid)
    else $error("bit valid too long");
  chk_speed_long_rst: assert property ($fell(speed_select_bit) |->
    (low_q >= RESET_LONG_CYC) || (last_q >= RESET_LONG_CYC)) else $error("speed cleared early");
  chk_func_exit_rst: assert property ($fell(func_active) |->
    (low_q >= DET_MIN) || (last_q >= DET_MIN)) else $error("function stage left early");
  chk_flag_addr: assert property ($rose(resume_select_flag) |-> ##[0:4] func_active)
    else $error("flag set without addressing");
  chk_oe_od_len: assert property ($fell(line_oe) && speed_select_bit |->
    oe_q <= sw_slave_pkg::CYC_PL_OD) else $error("pull too long at overdrive");
  chk_quiet_reset: assert property (low_q > sw_slave_pkg::CYC_RH_STD + 8 |-> !line_oe)
    else $error("slave pulls during reset");
endmodule : sw_slave_chk
bind sw_slave sw_slave_chk #(.RESET_LONG_CYC(RESET_LONG_CYC), .RESET_DET_STD(RESET_DET_STD),
  .PRES_LOW_STD(PRES_LOW_STD)) chk_u (.clk(clk), .reset(reset), .line_in(line_in),
  .line_out(line_out), .line_oe(line_oe), .func_active(func_active),
  .func_bit_valid(func_bit_valid), .speed_select_bit(speed_select_bit),
  .resume_select_flag(resume_select_flag));
`default_nettype wire

// [tb/sw_master.sv]
// Bus master model: reset pulses, presence sampling and bit slots.
// Assumes a 40 MHz clk and a pulled-up line resolved outside.
`timescale 1ns/10ps
`default_nettype none
module sw_master (
  // Clock and line
  input  wire logic clk,
  input  wire logic line,
  // Master pull-down
  output var logic  pull_low
);
  initial pull_low = 1'b0;
  task automatic hold(input int unsigned n);
    repeat (n) @(posedge clk);
    #1;
  endtask : hold
  // Sample mid-way into the presence low
  task automatic bus_reset(input int unsigned low_n, input logic od, output logic seen);
    pull_low = 1'b1;
    hold(low_n);
    pull_low = 1'b0;
    hold(od ? 360 : 1250);
    seen = ~line;
    hold(od ? 300 : 200);
  endtask : bus_reset
  // Slot of 200 or 1600 cycles; write-one lows are short, write-zero lows pass sampling
  task automatic slot(input logic b, input logic od, output logic rd);
    pull_low = 1'b1;
    hold(od ? 4 : 20);
    if (b) pull_low = 1'b0;
    hold(od ? 56 : 580);
    rd = line;
    hold(od ? 100 : 800);
    pull_low = 1'b0;
    hold(od ? 40 : 200);
  endtask : slot
  task automatic tx_byte(input logic [7:0] c, input logic od);
    logic rd;
    for (int i = 0; i < 8; i++) slot(c[i], od, rd);
  endtask : tx_byte
endmodule : sw_master
`default_nettype wire

// [tb/tb_top.sv]
// Testbench for the single-wire slave with a master model.
// Assumes the design package is compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  localparam logic [63:0] ROM = 64'h5A5A_0F0F_3C3C_9669; // Arbitrary identity
  logic clk, reset, line, pull_low, line_out, line_oe, func_active, func_bit_valid;
  logic func_bit, func_tx_bit, speed_select_bit, resume_select_flag, rd, seen, last_bit;
  int unsigned failures, n_compared, n_valid;
  assign line = !(pull_low || (line_oe && !line_out));
  always #12.5 clk = ~clk;
  always @(posedge clk) if (func_bit_valid === 1'b1) begin n_valid++; last_bit = func_bit; end
  sw_slave #(.ROM_ID(ROM), .RESET_LONG_CYC(4000), .RESET_DET_STD(2000), .PRES_LOW_STD(100))
    dut_u (.clk(clk), .reset(reset), .line_in(line), .line_out(line_out), .line_oe(line_oe),
    .func_active(func_active), .func_bit_valid(func_bit_valid), .func_bit(func_bit),
    .func_tx_bit(func_tx_bit), .speed_select_bit(speed_select_bit),
    .resume_select_flag(resume_select_flag));
  sw_master mst_u (.clk(clk), .line(line), .pull_low(pull_low));
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  task automatic t_power();
    `CHK(speed_select_bit, 1'b0)
    mst_u.bus_reset(2100, 1'b0, seen);
    `CHK(seen, 1'b1)
    mst_u.tx_byte(sw_slave_pkg::CMD_RESUME, 1'b0);
    `CHK(func_active, 1'b0)
    $display("test power done");
  endtask : t_power
  task automatic t_skip();
    mst_u.bus_reset(2100, 1'b0, seen);
    mst_u.tx_byte(sw_slave_pkg::CMD_OD_SKIP, 1'b0);
    `CHK(func_active, 1'b1)
    `CHK(speed_select_bit, 1'b1)
    `CHK(resume_select_flag, 1'b0)
    n_valid = 0;
    mst_u.slot(1'b0, 1'b1, rd);
    `CHK(last_bit, 1'b0)
    mst_u.slot(1'b1, 1'b1, rd);
    `CHK(last_bit, 1'b1)
    `CHK(n_valid, 2)
    func_tx_bit = 1'b0;
    mst_u.slot(1'b1, 1'b1, rd);
    `CHK(rd, 1'b0)
    func_tx_bit = 1'b1;
    mst_u.slot(1'b1, 1'b1, rd);
    `CHK(rd, 1'b1)
    $display("test skip done");
  endtask : t_skip
  task automatic t_match(input logic [63:0] id, input logic hit);
    mst_u.bus_reset(2000, 1'b1, seen);
    `CHK(seen, 1'b1)
    `CHK(speed_select_bit, 1'b1)
    mst_u.tx_byte(sw_slave_pkg::CMD_OD_MATCH, 1'b1);
    for (int i = 0; i < 64; i++) mst_u.slot(id[i], 1'b1, rd);
    `CHK(func_active, hit)
    `CHK(resume_select_flag, hit)
    `CHK(speed_select_bit, 1'b1)
    mst_u.bus_reset(2000, 1'b1, seen);
    mst_u.tx_byte(sw_slave_pkg::CMD_RESUME, 1'b1);
    `CHK(func_active, hit)
    $display("test match done");
  endtask : t_match
  task automatic t_long();
    mst_u.bus_reset(4100, 1'b0, seen);
    `CHK(seen, 1'b1)
    `CHK(speed_select_bit, 1'b0)
    $display("test long reset done");
  endtask : t_long
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    print_verdict();
  end
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    func_tx_bit = 1'b1;
    repeat (5) @(posedge clk);
    #1 reset = 1'b0;
    repeat (3) @(posedge clk);
    #1 t_power();
    t_skip();
    t_match(ROM, 1'b1);
    t_match(ROM ^ 64'h1, 1'b0);
    t_long();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
